// *** src/xfer_defs.svh ***
// Constants for the block transfer engine: offsets, codes, widths, reset values
`ifndef XFER_DEFS_SVH
`define XFER_DEFS_SVH
// Data path and memory address widths (byte address)
`define WW          16
`define AW          21
`define FIFO_DEPTH  8
// Register byte offsets on APB
`define OFS_CTRL    8'h00
`define OFS_SRC     8'h04
`define OFS_DST     8'h08
`define OFS_SIZE    8'h0C
`define OFS_PITCH   8'h10
`define OFS_COLOR   8'h14
`define OFS_KEY     8'h18
`define OFS_HOST    8'h1C
`define OFS_STAT    8'h20
// Control field layout and reset value
`define CTRL_START  0
`define CTRL_GFX    1
`define CTRL_W      12
`define CTRL_RST    12'h000
// Pixel organisation codes
`define FMT_PLANAR  2'h0
`define FMT_4BPP    2'h1
`define FMT_8BPP    2'h2
`define FMT_16BPP   2'h3
// Dots per transfer unit and mono bits per source word
`define DOTS_PLANE  4'h8
`define DOTS_PAIR   4'h2
`define DOTS_ONE    4'h1
`define MONO_FULL   5'h10
// Address steps in bytes
`define STEP_BYTE   21'h000001
`define STEP_WORD   21'h000002
`endif

// *** src/xfer_pkg.sv ***
// Types shared by the block transfer engine
`include "xfer_defs.svh"
package xfer_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_UNIT, S_HOST, S_SRC, S_SRC_W, S_DST, S_DST_W, S_MIX, S_WR
    } state_e;
    // Control register; start reads back as zero
    typedef struct packed {
        logic       transp;
        logic       fill;
        logic       mono;
        logic       src_host;
        logic [1:0] fmt;
        logic [3:0] rop;
        logic       gfx_mode;
        logic       start;
    } ctrl_s;
    // Request to the memory arbitrator (word address)
    typedef struct packed {
        logic            req;
        logic            we;
        logic [`AW-2:0]  addr;
        logic [1:0]      be;
        logic [`WW-1:0]  wdata;
    } mem_req_s;
endpackage : xfer_pkg

// *** src/block_transfer_engine.sv ***
// Block transfer engine with host data FIFO, APB registers and arbitrator port
// Operation
// [R1] Moves host data into video memory, or one memory area to another.
// [R2] Combines source and destination with one of sixteen raster operations.
// [R3] Expands one-bit source into 4, 8 or 16 bit destination pixels.
// [R4] Fills rectangles with a colour; transparency leaves chosen pixels untouched.
// [R5] Runs only in graphics mode; packed pixels of 4, 8 or 16 bits.
// [R6] Works eight dots per unit in planes, two dots in 4-bit packed mode.
// [R7] Memory reads and writes go as requests to the shared arbitrator.
// [R8] Clock to the engine stops when idle and resumes when work arrives.
// [R9] Each request holds address and data stable until granted.
// [R10] Busy from start until the final write is accepted.
`include "xfer_defs.svh"

module xfer_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  logic             clk,
    input  logic             rst_n,
    // Fill side
    input  logic             in_valid,
    output logic             in_ready,
    input  logic [WIDTH-1:0] in_data,
    // Drain side
    output logic             out_valid,
    input  logic             out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Handshakes and flags
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign in_ready  = cnt_q != (PW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : xfer_fifo

module block_transfer_engine (
    // Clock and reset
    input  logic                pclk,
    input  logic                presetn,
    // APB slave
    input  logic [7:0]          paddr,
    input  logic                psel,
    input  logic                penable,
    input  logic                pwrite,
    input  logic [31:0]         pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // Arbitrator port
    output xfer_pkg::mem_req_s  mem_o,
    input  logic                mem_gnt,
    input  logic                mem_rvalid,
    input  logic [`WW-1:0]      mem_rdata,
    // Status and clock gate enable
    output logic                busy,
    output logic                clk_run
);
    import xfer_pkg::*;

    ctrl_s          cfg_q;
    state_e         state_q;
    logic [`AW-1:0] src_q, dst_q, srow_q, drow_q, saddr_q, daddr_q;
    logic [15:0]    width_q, height_q, spitch_q, dpitch_q, x_q, y_q;
    logic [`WW-1:0] fg_q, bg_q, key_q, sdat_q, ddat_q, mono_q;
    logic [4:0]     mbits_q;
    logic           busy_q, clk_run_q;
    logic           acc, wr_host, start_go, mapped;
    logic           fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [`WW-1:0] fifo_out_data, sp, keep, wdata;
    logic [3:0]     dots;
    logic           need_src, last_x, last_y;

    // Raster operation: each result bit indexes the code by its source/dest pair
    function automatic logic [`WW-1:0] rop_f(logic [`WW-1:0] s, logic [`WW-1:0] d,
                                             logic [3:0] code);
        logic [`WW-1:0] r;
        r = '0;
        for (int i = 0; i < `WW; i++) begin
            r[i] = code[{s[i], d[i]}];
        end
        return r;
    endfunction : rop_f

    // Byte units in planar and 4-bit packed modes
    function automatic logic byte_unit(logic [1:0] fmt);
        return (fmt == `FMT_PLANAR) || (fmt == `FMT_4BPP);
    endfunction : byte_unit

    // Select a byte lane and repeat it on both lanes
    function automatic logic [`WW-1:0] lane_pick(logic [`WW-1:0] w, logic hi);
        return hi ? {2{w[15:8]}} : {2{w[7:0]}};
    endfunction : lane_pick

    // Spread mono bits, first dot in the top bit, over the unit's pixels
    function automatic logic [`WW-1:0] spread(logic [7:0] b, logic [1:0] fmt);
        case (fmt)
            `FMT_PLANAR: return {b, b};
            `FMT_4BPP:   return {2{{4{b[7]}}, {4{b[6]}}}};
            `FMT_8BPP:   return {{8{b[7]}}, {8{b[6]}}};
            default:     return {16{b[7]}};
        endcase
    endfunction : spread

    // Colour key: bits of packed pixels equal to the key; none in planar mode
    function automatic logic [`WW-1:0] key_mask(logic [`WW-1:0] s, logic [`WW-1:0] k,
                                                logic [1:0] fmt);
        logic [`WW-1:0] m;
        m = '0;
        case (fmt)
            `FMT_4BPP: begin
                for (int i = 0; i < 4; i++) begin
                    m[4*i+:4] = {4{s[4*i+:4] == k[4*i+:4]}};
                end
            end
            `FMT_8BPP: begin
                for (int i = 0; i < 2; i++) begin
                    m[8*i+:8] = {8{s[8*i+:8] == k[8*i+:8]}};
                end
            end
            `FMT_16BPP: m = {16{s == k}};
            default:    m = '0;
        endcase
        return m;
    endfunction : key_mask

    // Byte enables for a unit at a byte address
    function automatic logic [1:0] lane_be(logic [1:0] fmt, logic odd);
        return byte_unit(fmt) ? (odd ? 2'h2 : 2'h1) : 2'h3;
    endfunction : lane_be

    // APB decode; host data writes stall until the FIFO has room
    assign acc     = psel & penable & pready;
    assign wr_host = pwrite & (paddr == `OFS_HOST);
    assign mapped  = (paddr <= `OFS_STAT) & (paddr[1:0] == 2'h0);
    assign start_go = acc & pwrite & (paddr == `OFS_CTRL) & pwdata[`CTRL_START] & ~busy_q
                    & pwdata[`CTRL_GFX] & (width_q != '0) & (height_q != '0); // R5

    // Access phase answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready & ~(wr_host & ~fifo_in_ready);
            if (psel & penable & ~pready) begin
                pslverr <= ~mapped;
                case (paddr)
                    `OFS_CTRL:  prdata <= 32'(cfg_q);
                    `OFS_SRC:   prdata <= 32'(src_q);
                    `OFS_DST:   prdata <= 32'(dst_q);
                    `OFS_SIZE:  prdata <= {height_q, width_q};
                    `OFS_PITCH: prdata <= {dpitch_q, spitch_q};
                    `OFS_COLOR: prdata <= {bg_q, fg_q};
                    `OFS_KEY:   prdata <= 32'(key_q);
                    `OFS_STAT:  prdata <= 32'({~fifo_out_valid, busy_q});
                    default:    prdata <= '0;
                endcase
            end
        end
    end

    // Configuration; frozen while an operation runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q    <= `CTRL_RST;
            src_q    <= '0;
            dst_q    <= '0;
            width_q  <= '0;
            height_q <= '0;
            spitch_q <= '0;
            dpitch_q <= '0;
            fg_q     <= '0;
            bg_q     <= '0;
            key_q    <= '0;
        end else if (acc & pwrite & ~busy_q) begin
            case (paddr)
                `OFS_CTRL:  cfg_q <= ctrl_s'({pwdata[`CTRL_W-1:1], 1'b0});
                `OFS_SRC:   src_q <= pwdata[`AW-1:0];
                `OFS_DST:   dst_q <= pwdata[`AW-1:0];
                `OFS_SIZE:  {height_q, width_q} <= pwdata;
                `OFS_PITCH: {dpitch_q, spitch_q} <= pwdata;
                `OFS_COLOR: {bg_q, fg_q} <= pwdata;
                `OFS_KEY:   key_q <= pwdata[`WW-1:0];
                default:    ;
            endcase
        end
    end

    // Host data buffer, drained only by the engine's host fetch
    assign fifo_out_ready = (state_q == S_HOST); // R1
    xfer_fifo #(.WIDTH(`WW), .DEPTH(`FIFO_DEPTH)) host_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (acc & wr_host),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata[`WW-1:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Unit shape and source pixel selection
    always_comb begin
        case (cfg_q.fmt)
            `FMT_PLANAR: dots = `DOTS_PLANE; // R6
            `FMT_16BPP:  dots = `DOTS_ONE;
            default:     dots = `DOTS_PAIR; // R6
        endcase
        need_src = ~cfg_q.fill & ~(cfg_q.mono & (mbits_q >= {1'b0, dots}));
        last_x   = x_q == width_q - 16'h0001;
        last_y   = y_q == height_q - 16'h0001;
        keep     = '0;
        if (cfg_q.fill) begin
            sp = fg_q; // R4
        end else if (cfg_q.mono) begin
            sp = (spread(mono_q[15:8], cfg_q.fmt) & fg_q)
               | (~spread(mono_q[15:8], cfg_q.fmt) & bg_q); // R3
            if (cfg_q.transp) begin
                keep = ~spread(mono_q[15:8], cfg_q.fmt); // R4
            end
        end else begin
            sp = sdat_q;
            if (cfg_q.transp) begin
                keep = key_mask(sdat_q, key_q, cfg_q.fmt); // R4
            end
        end
        wdata = (rop_f(sp, ddat_q, cfg_q.rop) & ~keep) | (ddat_q & keep); // R2
    end

    // Transfer sequencer and arbitrator requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            busy_q  <= 1'b0;
            mem_o   <= '0;
            {x_q, y_q} <= '0;
            {srow_q, drow_q, saddr_q, daddr_q} <= '0;
            {sdat_q, ddat_q, mono_q} <= '0;
            mbits_q <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_go) begin
                        state_q <= S_UNIT;
                        busy_q  <= 1'b1; // R10
                        x_q     <= '0;
                        y_q     <= '0;
                        {srow_q, saddr_q} <= {src_q, src_q};
                        {drow_q, daddr_q} <= {dst_q, dst_q};
                        mbits_q <= '0;
                    end
                end
                S_UNIT: begin
                    if (!need_src) begin
                        mem_o   <= '{1'b1, 1'b0, daddr_q[`AW-1:1],
                                     lane_be(cfg_q.fmt, daddr_q[0]), '0};
                        state_q <= S_DST;
                    end else if (cfg_q.src_host) begin
                        state_q <= S_HOST; // R1
                    end else begin
                        mem_o   <= '{1'b1, 1'b0, saddr_q[`AW-1:1], 2'h3, '0}; // R7
                        state_q <= S_SRC;
                    end
                end
                S_HOST, S_SRC_W: begin
                    if ((state_q == S_HOST) ? fifo_out_valid : mem_rvalid) begin
                        if (cfg_q.mono) begin
                            mono_q  <= (state_q == S_HOST) ? fifo_out_data : mem_rdata;
                            mbits_q <= `MONO_FULL; // R3
                            if (state_q == S_SRC_W) begin
                                saddr_q <= saddr_q + `STEP_WORD;
                            end
                        end else begin
                            sdat_q <= (state_q == S_HOST) ? fifo_out_data :
                                      byte_unit(cfg_q.fmt) ? lane_pick(mem_rdata, saddr_q[0])
                                                           : mem_rdata;
                        end
                        mem_o   <= '{1'b1, 1'b0, daddr_q[`AW-1:1],
                                     lane_be(cfg_q.fmt, daddr_q[0]), '0};
                        state_q <= S_DST;
                    end
                end
                S_SRC, S_DST: begin
                    if (mem_gnt) begin
                        mem_o.req <= 1'b0; // R9
                        state_q   <= (state_q == S_SRC) ? S_SRC_W : S_DST_W;
                    end
                end
                S_DST_W: begin
                    if (mem_rvalid) begin
                        ddat_q  <= byte_unit(cfg_q.fmt) ? lane_pick(mem_rdata, daddr_q[0])
                                                        : mem_rdata;
                        state_q <= S_MIX;
                    end
                end
                S_MIX: begin
                    mem_o   <= '{1'b1, 1'b1, daddr_q[`AW-1:1],
                                 lane_be(cfg_q.fmt, daddr_q[0]), wdata}; // R2
                    if (cfg_q.mono) begin
                        mono_q  <= mono_q << dots;
                        mbits_q <= mbits_q - {1'b0, dots};
                    end
                    state_q <= S_WR;
                end
                S_WR: begin
                    if (mem_gnt) begin
                        mem_o.req <= 1'b0; // R9
                        state_q   <= S_UNIT;
                        if (!last_x) begin
                            x_q     <= x_q + 16'h0001;
                            daddr_q <= daddr_q + (byte_unit(cfg_q.fmt) ? `STEP_BYTE : `STEP_WORD);
                            if (!cfg_q.mono) begin
                                saddr_q <= saddr_q
                                    + (byte_unit(cfg_q.fmt) ? `STEP_BYTE : `STEP_WORD);
                            end
                        end else if (last_y) begin
                            state_q <= S_IDLE;
                            busy_q  <= 1'b0; // R10
                        end else begin
                            x_q     <= '0;
                            y_q     <= y_q + 16'h0001;
                            mbits_q <= '0;
                            srow_q  <= srow_q + `AW'(spitch_q);
                            drow_q  <= drow_q + `AW'(dpitch_q);
                            saddr_q <= srow_q + `AW'(spitch_q);
                            daddr_q <= drow_q + `AW'(dpitch_q);
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Clock gate enable: on while running or host data waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_run_q <= 1'b0;
        end else begin
            clk_run_q <= start_go | (busy_q & ~(state_q == S_WR & mem_gnt & last_x & last_y))
                       | fifo_out_valid; // R8
        end
    end

    assign busy    = busy_q;
    assign clk_run = clk_run_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_req_held: assert property (mem_o.req && !mem_gnt |=> mem_o.req && $stable(mem_o)) // R9
        else $error("request changed before grant");
    chk_req_busy: assert property (mem_o.req |-> busy_q) // R7
        else $error("memory request while idle");
    chk_busy_start: assert property (start_go |=> busy_q && state_q == S_UNIT) // R10
        else $error("busy not raised on start");
    chk_busy_end: assert property (state_q == S_WR && mem_gnt && last_x && last_y
        |=> !busy_q && state_q == S_IDLE) // R10
        else $error("busy not dropped after final write");
    chk_gfx_gate: assert property (acc && pwrite && paddr == `OFS_CTRL && !busy_q
        && !pwdata[`CTRL_GFX] |=> !busy_q) // R5
        else $error("started outside graphics mode");
    chk_clk_stop: assert property (!busy_q && !start_go && !fifo_out_valid |=> !clk_run_q) // R8
        else $error("clock enable on while idle");
    chk_clk_run: assert property (busy_q |-> clk_run_q) // R8
        else $error("clock enable off while busy");
    chk_fill_src: assert property (busy_q && cfg_q.fill |-> state_q != S_SRC
        && state_q != S_HOST) // R4
        else $error("fill fetched a source");
    chk_rop_write: assert property (state_q == S_DST_W && mem_rvalid
        |=> ##1 mem_o.req && mem_o.we) // R2
        else $error("no write after destination read");
    chk_byte_lane: assert property (mem_o.req && byte_unit(cfg_q.fmt) && mem_o.we
        |-> $onehot(mem_o.be)) // R6
        else $error("byte unit wrote both lanes");
    chk_mono_load: assert property (state_q == S_SRC_W && mem_rvalid && cfg_q.mono
        |=> mbits_q == `MONO_FULL) // R3
        else $error("mono word not loaded");
    chk_host_pop: assert property (fifo_out_ready |-> busy_q && cfg_q.src_host) // R1
        else $error("host data drained outside host transfer");

    cov_fill_done: cover property (busy_q && cfg_q.fill ##1 !busy_q);
    cov_mono_host: cover property (state_q == S_HOST && fifo_out_valid && cfg_q.mono);
    cov_key_write: cover property (state_q == S_MIX && keep != '0);
    cov_stall: cover property (mem_o.req && !mem_gnt ##1 mem_o.req && mem_gnt);
endmodule : block_transfer_engine

// *** test/arb_model.sv ***
// Behavioural model of the shared memory arbitrator with a small video memory
`include "xfer_defs.svh"
module arb_model (
    // Clock, reset and pacing
    input  logic               pclk,
    input  logic               presetn,
    input  logic               slow,
    // Engine side
    input  xfer_pkg::mem_req_s mem_o,
    output logic               mem_gnt,
    output logic               mem_rvalid,
    output logic [`WW-1:0]     mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import xfer_pkg::*;
    logic [15:0] mem [0:1023];
    logic [1:0]  wait_q;
    logic [1:0]  pace_q;
    logic        rd_q;
    logic [9:0]  ra_q;
    // Grant after a short wait, apply writes, return read data a cycle after the grant
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_gnt    <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 16'h0000;
            rd_q       <= 1'b0;
            wait_q     <= 2'h0;
            pace_q     <= 2'h0;
        end else begin
            mem_gnt    <= 1'b0;
            mem_rvalid <= rd_q;
            rd_q       <= 1'b0;
            pace_q     <= pace_q + 2'h1;
            mem_rdata  <= rd_q ? mem[ra_q] : ~mem_rdata; // Idle bus never holds old data
            if (mem_o.req && !mem_gnt) begin
                if (wait_q != 2'h0) begin
                    wait_q <= wait_q - 2'h1;
                end else begin
                    mem_gnt <= 1'b1;
                    wait_q  <= slow ? pace_q : 2'h0;
                    rd_q    <= !mem_o.we;
                    ra_q    <= mem_o.addr[9:0];
                    for (int b = 0; b < 2; b++) begin
                        if (mem_o.we && mem_o.be[b]) begin
                            mem[mem_o.addr[9:0]][b*8+:8] <= mem_o.wdata[b*8+:8];
                        end
                    end
                end
            end
        end
    end
endmodule : arb_model

// *** test/block_transfer_engine_tb.sv ***
// Self-checking bench for the block transfer engine
`include "xfer_defs.svh"
module block_transfer_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import xfer_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, mem_gnt, mem_rvalid, busy, clk_run;
    logic [15:0] mem_rdata;
    mem_req_s    mem_o;
    logic [15:0] ref_mem [0:1023];
    logic [15:0] late [$];
    logic [31:0] seed = 32'h34DDA667;
    int          miscompares = 0;
    int          cmp_count = 0;

    block_transfer_engine DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .mem_o, .mem_gnt, .mem_rvalid, .mem_rdata, .busy, .clk_run);
    arb_model arb (.pclk, .presetn, .slow, .mem_o, .mem_gnt, .mem_rvalid, .mem_rdata);

    // 125 MHz clock
    initial begin
        forever #4 pclk = ~pclk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // One APB transfer: setup, access held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 500);
        if (n >= 500) begin
            chk(32'h0, 32'h1, "apb wait");
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic ee,
                          input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, what);
        chk({31'h0, e}, {31'h0, ee}, what);
    endtask : rd_chk

    // Start, feed late host words, then wait for idle
    task automatic run(input logic [31:0] ctrl);
        int n;
        n = 0;
        wr(`OFS_CTRL, ctrl);
        chk({31'h0, busy}, 32'h1, "busy after start");
        while (late.size() > 0) wr(`OFS_HOST, {16'h0, late.pop_front()});
        while (busy !== 1'b0 && n < 5000) begin
            chk({31'h0, clk_run}, 32'h1, "clk_run while busy");
            @(posedge pclk);
            n++;
        end
        chk({31'h0, busy}, 32'h0, "busy at end");
    endtask : run

    task automatic mem_chk(input int w, input string what);
        chk({16'h0, arb.mem[w]}, {16'h0, ref_mem[w]}, what);
    endtask : mem_chk

    initial begin
        logic [31:0] v;
        logic [15:0] s, d, r, m;
        logic [15:0] host [0:8];
        int          w;
        for (int i = 0; i < 1024; i++) begin
            v = xs();
            ref_mem[i] = v[15:0];
            arb.mem[i] = v[15:0];
        end
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, write-only and unmapped places
        chk({30'h0, busy, clk_run}, 32'h0, "idle at reset");
        rd_chk(`OFS_CTRL, {20'h0, `CTRL_RST}, 1'b0, "ctrl reset");
        rd_chk(`OFS_STAT, 32'h2, 1'b0, "stat reset");
        rd_chk(`OFS_HOST, 32'h0, 1'b0, "host reads zero");
        rd_chk(8'h24, 32'h0, 1'b1, "unmapped");
        rd_chk(8'h02, 32'h0, 1'b1, "misaligned");
        $display("test registers done");
        // Start refused without graphics mode or with zero width
        wr(`OFS_SIZE, 32'h0001_0001);
        wr(`OFS_CTRL, 32'hC1);
        chk({31'h0, busy}, 32'h0, "start without gfx");
        rd_chk(`OFS_CTRL, 32'hC0, 1'b0, "ctrl readback");
        wr(`OFS_SIZE, 32'h0001_0000);
        wr(`OFS_CTRL, 32'hC3);
        chk({31'h0, busy}, 32'h0, "start with zero width");
        $display("test refusal done");
        // All sixteen raster operations, memory to memory
        wr(`OFS_SIZE, 32'h0001_0001);
        for (int op = 0; op < 16; op++) begin
            slow <= op[0];
            wr(`OFS_SRC, 32'h100 + 2 * op);
            wr(`OFS_DST, 32'h200 + 2 * op);
            run(32'hC3 | (op << 2));
            s = ref_mem[128 + op];
            d = ref_mem[256 + op];
            for (int b = 0; b < 16; b++) r[b] = op[{s[b], d[b]}];
            ref_mem[256 + op] = r;
            mem_chk(256 + op, "rop result");
        end
        $display("test raster ops done");
        // Host copy through a full FIFO with a slow arbitrator
        slow <= 1'b1;
        for (int i = 0; i < 9; i++) host[i] = 16'(xs());
        wr(`OFS_DST, 32'h300);
        wr(`OFS_SIZE, 32'h0001_0009);
        for (int i = 0; i < 8; i++) wr(`OFS_HOST, {16'h0, host[i]});
        rd_chk(`OFS_STAT, 32'h0, 1'b0, "fifo holds data");
        chk({31'h0, clk_run}, 32'h1, "clk_run with data");
        late.push_back(host[8]);
        run(32'h1F3);
        for (int i = 0; i < 9; i++) begin
            ref_mem[384 + i] = host[i];
            mem_chk(384 + i, "host copy");
        end
        $display("test host copy done");
        // Rectangle fill over two rows
        v = xs();
        wr(`OFS_COLOR, v);
        wr(`OFS_DST, 32'h400);
        wr(`OFS_PITCH, 32'h0010_0000);
        wr(`OFS_SIZE, 32'h0002_0002);
        run(32'h4F3);
        for (int i = 0; i < 4; i++) begin
            w = 512 + 8 * (i / 2) + i % 2;
            ref_mem[w] = v[15:0];
            mem_chk(w, "fill");
        end
        $display("test fill done");
        // Mono expansion with transparent zero dots
        v = xs();
        m = 16'(xs());
        wr(`OFS_COLOR, v);
        wr(`OFS_DST, 32'h500);
        wr(`OFS_SIZE, 32'h0001_0010);
        late.push_back(m);
        run(32'hBF3);
        for (int i = 0; i < 16; i++) begin
            if (m[15 - i]) ref_mem[640 + i] = v[15:0];
            mem_chk(640 + i, "mono expand");
        end
        // Byte lanes
        wr(`OFS_SRC, 32'h101);
        wr(`OFS_DST, 32'h602);
        run(32'h73);
        for (int i = 0; i < 8; i++) begin
            ref_mem[769 + i] = {ref_mem[129 + i][7:0], ref_mem[128 + i][15:8]};
            mem_chk(769 + i, "byte copy");
        end
        rd_chk(`OFS_STAT, 32'h2, 1'b0, "stat idle");
        chk({31'h0, clk_run}, 32'h0, "clock stopped when idle");
        $display("test mono done");
        close_out();
    end
endmodule : block_transfer_engine_tb
